/* File: design/spb_ctrl.sv */
// controller end: generates strobes, drives commands, collects read bursts
`timescale 1ns/1ps
`default_nettype none
module spb_ctrl #(
  parameter int DATA_W = spb_pkg::DATA_W,
  parameter int ADDR_W = spb_pkg::ADDR_W,
  parameter int MASK_W = spb_pkg::lanes(DATA_W)
) (
  input  wire logic              clk_sys,
  input  wire logic              sys_rst,
  output logic                   cmd_ready,
  input  wire logic              wr_req,
  input  wire logic [ADDR_W-1:0] wr_addr,
  input  wire logic [DATA_W-1:0] wr_data0,
  input  wire logic [DATA_W-1:0] wr_data1,
  input  wire logic [MASK_W-1:0] wr_en0,
  input  wire logic [MASK_W-1:0] wr_en1,
  input  wire logic              rd_req,
  input  wire logic [ADDR_W-1:0] rd_addr,
  output logic                   rd_valid,
  output logic [DATA_W-1:0]      rd_data0,
  output logic [DATA_W-1:0]      rd_data1,
  spb_link_if.ctl                link
);
  import spb_pkg::*;

  localparam int CW = $clog2(STROBE_HALF_CYC + 1);
  localparam logic [CW-1:0] LAST = CW'(STROBE_HALF_CYC - 1);
  localparam logic [CW-1:0] MID  = CW'(SETUP_CYC);

  spb_phase_t        phase_reg;
  logic [CW-1:0]     cnt_reg;
  logic              k_up;
  logic              k_dn;
  logic              take;
  logic              mid_high;
  logic              k_reg;
  logic              wps_n_reg;
  logic              rps_n_reg;
  logic [ADDR_W-1:0] idx_reg;
  logic [DATA_W-1:0] wbus_reg;
  logic [MASK_W-1:0] mask_n_reg;
  logic [ADDR_W-1:0] wa_hold_reg;
  logic [DATA_W-1:0] wd1_hold_reg;
  logic [MASK_W-1:0] we1_hold_reg;
  logic [DATA_W-1:0] rb1_reg;
  logic [DATA_W-1:0] rb2_reg;
  logic [DATA_W-1:0] rb3_reg;
  logic [DATA_W-1:0] rb_lvl_reg;
  logic              rd_issue_reg;
  logic              rd_beat_reg;
  logic              cmd_ready_reg;
  logic              rd_valid_reg;
  logic [DATA_W-1:0] rd_data0_reg;
  logic [DATA_W-1:0] rd_data1_reg;

  assign k_up     = (phase_reg == PH_LOW) && (cnt_reg == LAST);
  assign k_dn     = (phase_reg == PH_HIGH) && (cnt_reg == LAST);
  assign take     = cmd_ready_reg;
  assign mid_high = (phase_reg == PH_HIGH) && (cnt_reg == MID);

  // strobe divider; both pairs run in phase
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      phase_reg <= PH_LOW;
      cnt_reg   <= '0;
      k_reg     <= 1'b0;
    end
    else if (cnt_reg == LAST)
    begin
      cnt_reg <= '0;
      k_reg   <= ~k_reg;
      case (phase_reg)
        PH_LOW:  phase_reg <= PH_HIGH;
        PH_HIGH: phase_reg <= PH_LOW;
        default: phase_reg <= PH_LOW;
      endcase
    end
    else
      cnt_reg <= cnt_reg + 1'b1;
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      cmd_ready_reg <= 1'b0;
    else
      cmd_ready_reg <= (phase_reg == PH_LOW) && (cnt_reg == MID - 1'b1);
  end

  // pins change mid-phase so they are stable around each strobe rise
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      wps_n_reg    <= RST_SEL_N;
      rps_n_reg    <= RST_SEL_N;
      idx_reg      <= '0;
      wbus_reg     <= '0;
      mask_n_reg   <= '1;
      wa_hold_reg  <= '0;
      wd1_hold_reg <= '0;
      we1_hold_reg <= '0;
    end
    else if (take)
    begin
      wps_n_reg    <= ~wr_req;
      rps_n_reg    <= ~rd_req;
      idx_reg      <= rd_addr;
      wbus_reg     <= wr_data0;
      mask_n_reg   <= ~wr_en0;
      wa_hold_reg  <= wr_addr;
      wd1_hold_reg <= wr_data1;
      we1_hold_reg <= wr_en1;
    end
    else if (mid_high)
    begin
      idx_reg    <= wa_hold_reg;
      wbus_reg   <= wd1_hold_reg;
      mask_n_reg <= ~we1_hold_reg;
    end
  end

  // read bus comes from a pin: three stages, accepted when two agree
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      rb1_reg    <= '0;
      rb2_reg    <= '0;
      rb3_reg    <= '0;
      rb_lvl_reg <= '0;
    end
    else
    begin
      rb1_reg <= link.read_bus;
      rb2_reg <= rb1_reg;
      rb3_reg <= rb2_reg;
      if (rb2_reg == rb3_reg)
        rb_lvl_reg <= rb3_reg;
    end
  end

  // beat 0 is driven one strobe period after the command, beat 1 half later;
  // each is sampled a half period after it was launched
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      rd_issue_reg <= 1'b0;
      rd_beat_reg  <= 1'b0;
      rd_valid_reg <= 1'b0;
      rd_data0_reg <= '0;
      rd_data1_reg <= '0;
    end
    else
    begin
      rd_valid_reg <= 1'b0;
      if (k_up)
      begin
        rd_issue_reg <= ~rps_n_reg;
        rd_beat_reg  <= rd_issue_reg;
        if (rd_beat_reg)
        begin
          rd_data1_reg <= rb_lvl_reg;
          rd_valid_reg <= 1'b1;
        end
      end
      else if (k_dn && rd_beat_reg)
        rd_data0_reg <= rb_lvl_reg;
    end
  end

  assign link.in_strobe_pos    = k_reg;
  assign link.in_strobe_neg    = ~k_reg;
  assign link.out_strobe_pos   = k_reg;
  assign link.out_strobe_neg   = ~k_reg;
  assign link.write_port_sel_n = wps_n_reg;
  assign link.read_port_sel_n  = rps_n_reg;
  assign link.word_index       = idx_reg;
  assign link.write_bus        = wbus_reg;
  assign link.write_mask_n     = mask_n_reg;
  assign cmd_ready             = cmd_ready_reg;
  assign rd_valid              = rd_valid_reg;
  assign rd_data0              = rd_data0_reg;
  assign rd_data1              = rd_data1_reg;
endmodule
`default_nettype wire

/* File: design/spb_device.sv */
// memory device end: captures commands on strobe edges, stores, returns bursts
//
// Summary of operation
// - write data captured on both input strobe edges
// - low write select at rise starts write
// - high write select ignores write bus
// - 8-bit variant: two nibble masks gate nibbles
// - wider variants: 9-bit lane masks gate lanes
// - each mask sampled with its data beat
// - masks apply per beat independently
// - masked-off portion never stored
// - read index on rise, write index on fall
// - two array halves; index width per variant
// - deselected port ignores word index
// - read beats on output strobe pair edges, input pair in single clock mode
// - read bus released when read port idle
// - low read select at rise starts read
// - deselect: finish burst, release after next rise
// - read returns two sequential words
// - every access launched by input strobe rise
`timescale 1ns/1ps
`default_nettype none
module spb_device #(
  parameter int DATA_W = spb_pkg::DATA_W,
  parameter int ADDR_W = spb_pkg::ADDR_W
) (
  input  wire logic  clk_sys,
  input  wire logic  sys_rst,
  input  wire logic  single_clock,
  spb_link_if.dev    link
);
  import spb_pkg::*;

  localparam int LW = lane_w(DATA_W);
  localparam int NL = DATA_W / LW;
  localparam int IW = 6 + ADDR_W + DATA_W + NL;
  // idle pins: pos strobes low, complements high, selects high
  localparam logic [3:0]    STB_IDLE = 4'h5;
  localparam logic [IW-1:0] PIN_IDLE = {STB_IDLE, RST_SEL_N, RST_SEL_N,
                                        {(IW-6){1'b0}}};

  logic [IW-1:0]     pin_in;
  logic [IW-1:0]     s1_reg;
  logic [IW-1:0]     s2_reg;
  logic [IW-1:0]     s3_reg;
  logic [3:0]        stb2;
  logic [3:0]        stb3;
  logic [3:0]        lvl_reg;
  logic [3:0]        lvl_next;
  logic [3:0]        rise;
  logic              wps3;
  logic              rps3;
  logic [ADDR_W-1:0] idx3;
  logic [DATA_W-1:0] wbus3;
  logic [NL-1:0]     mask3;
  logic              k_rise;
  logic              kn_rise;
  logic              op_rise;
  logic              on_rise;
  logic              wr_act_reg;
  logic [DATA_W-1:0] wd0_reg;
  logic [NL-1:0]     wm0_reg;
  logic              rd_pend_reg;
  logic [ADDR_W-1:0] rd_addr_reg;
  logic [ADDR_W-1:0] rd_hold_reg;
  logic              burst_reg;
  logic [DATA_W-1:0] lo_rd;
  logic [DATA_W-1:0] hi_rd;
  logic [DATA_W-1:0] read_q_reg;
  logic              oe_n_reg;

  assign pin_in = {link.in_strobe_pos, link.in_strobe_neg,
                   link.out_strobe_pos, link.out_strobe_neg,
                   link.write_port_sel_n, link.read_port_sel_n,
                   link.word_index, link.write_bus, link.write_mask_n};

  // three-stage pin synchroniser; only stages two and three are inspected
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      // idle levels, so high complement strobes give no false rise
      s1_reg <= PIN_IDLE;
      s2_reg <= PIN_IDLE;
      s3_reg <= PIN_IDLE;
    end
    else
    begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  assign stb2 = s2_reg[IW-1 -: 4];
  assign stb3 = s3_reg[IW-1 -: 4];
  assign {wps3, rps3, idx3, wbus3, mask3} = s3_reg[IW-5:0];

  // a strobe change counts only once stages two and three agree
  assign lvl_next = (stb3 & ~(stb2 ^ stb3)) | (lvl_reg & (stb2 ^ stb3));
  assign rise     = lvl_next & ~lvl_reg;

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      lvl_reg <= STB_IDLE;
    else
      lvl_reg <= lvl_next;
  end

  assign k_rise  = rise[3];
  assign kn_rise = rise[2];
  // single clock mode times read data from the input strobe pair
  assign op_rise = single_clock ? rise[3] : rise[1];
  assign on_rise = single_clock ? rise[2] : rise[0];

  // write command and first beat
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      wr_act_reg <= 1'b0;
      wd0_reg    <= '0;
      wm0_reg    <= '1;
    end
    else if (k_rise)
    begin
      wr_act_reg <= ~wps3;
      if (!wps3)
      begin
        wd0_reg <= wbus3;
        wm0_reg <= mask3;
      end
    end
    else if (kn_rise)
      wr_act_reg <= 1'b0;
  end

  // read command; index ignored when the read port is deselected
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      rd_pend_reg <= 1'b0;
      rd_addr_reg <= '0;
    end
    else if (k_rise)
    begin
      rd_pend_reg <= ~rps3;
      if (!rps3)
        rd_addr_reg <= idx3;
    end
  end

  // two halves per lane: beat 0 half and beat 1 half of each burst
  for (genvar g = 0; g < NL; g++)
  begin : g_lane
    logic [LW-1:0] lo_mem [2**ADDR_W];
    logic [LW-1:0] hi_mem [2**ADDR_W];

    // write index arrives on the falling-strobe edge with beat 1
    always_ff @(posedge clk_sys)
    begin
      if (kn_rise && wr_act_reg)
      begin
        if (!wm0_reg[g])
          lo_mem[idx3] <= wd0_reg[g*LW +: LW];
        if (!mask3[g])
          hi_mem[idx3] <= wbus3[g*LW +: LW];
      end
    end

    assign lo_rd[g*LW +: LW] = lo_mem[rd_addr_reg];
    assign hi_rd[g*LW +: LW] = hi_mem[rd_hold_reg];
  end

  // read bursts: beat 0 on the output rise after the command, beat 1 on
  // the complementary rise; an idle output rise releases the bus
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      read_q_reg  <= '0;
      oe_n_reg    <= RST_OE_N;
      burst_reg   <= 1'b0;
      rd_hold_reg <= '0;
    end
    else if (op_rise)
    begin
      burst_reg <= rd_pend_reg;
      if (rd_pend_reg)
      begin
        read_q_reg  <= lo_rd;
        oe_n_reg    <= 1'b0;
        rd_hold_reg <= rd_addr_reg;
      end
      else
        oe_n_reg <= 1'b1;
    end
    else if (on_rise && burst_reg)
    begin
      read_q_reg <= hi_rd;
      burst_reg  <= 1'b0;
    end
  end

  assign link.read_q    = read_q_reg;
  assign link.read_oe_n = oe_n_reg;
endmodule
`default_nettype wire

/* File: design/spb_link_if.sv */
// pin-level link between the memory device and its controller
`timescale 1ns/1ps
`default_nettype none
interface spb_link_if #(
  parameter int DATA_W = spb_pkg::DATA_W,
  parameter int ADDR_W = spb_pkg::ADDR_W,
  parameter int MASK_W = spb_pkg::lanes(DATA_W)
);
  logic              in_strobe_pos;
  logic              in_strobe_neg;
  logic              out_strobe_pos;
  logic              out_strobe_neg;
  logic              write_port_sel_n;
  logic              read_port_sel_n;
  logic [ADDR_W-1:0] word_index;
  logic [DATA_W-1:0] write_bus;
  logic [MASK_W-1:0] write_mask_n;
  logic [DATA_W-1:0] read_q;
  logic              read_oe_n;
  wire  [DATA_W-1:0] read_bus;

  // released bus settles to its pull-down level while the enable is high
  assign read_bus = read_oe_n ? {DATA_W{1'b0}} : read_q;

  modport dev (
    input  in_strobe_pos,
    input  in_strobe_neg,
    input  out_strobe_pos,
    input  out_strobe_neg,
    input  write_port_sel_n,
    input  read_port_sel_n,
    input  word_index,
    input  write_bus,
    input  write_mask_n,
    output read_q,
    output read_oe_n
  );

  modport ctl (
    output in_strobe_pos,
    output in_strobe_neg,
    output out_strobe_pos,
    output out_strobe_neg,
    output write_port_sel_n,
    output read_port_sel_n,
    output word_index,
    output write_bus,
    output write_mask_n,
    input  read_bus
  );
endinterface
`default_nettype wire

/* File: design/spb_pkg.sv */
// shared constants and types for the split-port burst memory link
package spb_pkg;
  localparam int DATA_W          = 36;
  localparam int ADDR_W          = 20;
  localparam int NIB_W           = 4;
  localparam int LANE9_W         = 9;
  localparam int NIB_DATA_W      = 8;
  localparam int CLK_PERIOD_PS   = 5000;
  localparam int STROBE_HALF_NS  = 50;
  localparam int STROBE_HALF_CYC = (STROBE_HALF_NS * 1000) / CLK_PERIOD_PS;
  localparam int SETUP_CYC       = STROBE_HALF_CYC / 2;
  localparam logic RST_SEL_N     = 1'b1;
  localparam logic RST_OE_N      = 1'b1;

  function automatic int lane_w(input int dw);
    return (dw == NIB_DATA_W) ? NIB_W : LANE9_W;
  endfunction

  function automatic int lanes(input int dw);
    return dw / lane_w(dw);
  endfunction

  typedef enum logic [1:0] {
    PH_LOW  = 2'b01,
    PH_HIGH = 2'b10
  } spb_phase_t;
endpackage

/* File: verification/spb_link_assertions.sv */
// link-level checks for the split-port burst memory link
`timescale 1ns/1ps
`default_nettype none
module spb_link_assertions #(
  parameter int DATA_W = 36,
  parameter int ADDR_W = 20,
  parameter int MASK_W = 4
) (
  input wire logic              clk_sys,
  input wire logic              sys_rst,
  input wire logic              in_strobe_pos,
  input wire logic              in_strobe_neg,
  input wire logic              out_strobe_pos,
  input wire logic              write_port_sel_n,
  input wire logic              read_port_sel_n,
  input wire logic [ADDR_W-1:0] word_index,
  input wire logic [DATA_W-1:0] write_bus,
  input wire logic [MASK_W-1:0] write_mask_n,
  input wire logic [DATA_W-1:0] read_q,
  input wire logic              read_oe_n
);
  logic [7:0] rd_age_reg;
  logic [7:0] run_age_reg;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // cycles since a read launch; saturates so idle stays obvious
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      rd_age_reg <= 8'hff;
    else if ($rose(in_strobe_pos) && !read_port_sel_n)
      rd_age_reg <= 8'h00;
    else if (rd_age_reg != 8'hff)
      rd_age_reg <= rd_age_reg + 8'h01;
  end
  // age of the first read of a back-to-back run; later reads keep it
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      run_age_reg <= 8'hff;
    else if ($rose(in_strobe_pos) && !read_port_sel_n &&
             rd_age_reg > 8'h13)
      run_age_reg <= 8'h00;
    else if (run_age_reg != 8'hff)
      run_age_reg <= run_age_reg + 8'h01;
  end
  sequence s_high_half;
    in_strobe_pos [*8] ##3 !in_strobe_pos;
  endsequence
  sequence s_burst;
    (!read_oe_n && $stable(read_q)) [*8];
  endsequence
  AST_STROBE_PAIR: assert property (
    in_strobe_neg == !in_strobe_pos)
    else $error("input strobes not complementary");
  AST_OUT_PAIR: assert property (
    out_strobe_pos == in_strobe_pos)
    else $error("output strobe not aligned");
  AST_HIGH_HALF: assert property (
    $rose(in_strobe_pos) |-> s_high_half)
    else $error("strobe half period wrong");
  AST_RD_FIELDS: assert property (
    $rose(in_strobe_pos) |-> ($stable(read_port_sel_n) &&
      $stable(write_port_sel_n) && $stable(word_index) &&
      $stable(write_bus)) [*3])
    else $error("fields move at strobe rise");
  AST_WR_FIELDS: assert property (
    $rose(in_strobe_neg) |-> ($stable(word_index) &&
      $stable(write_bus) && $stable(write_mask_n)) [*3])
    else $error("write beat moves at strobe fall");
  AST_BEAT0_TIME: assert property (
    $fell(read_oe_n) |-> run_age_reg inside {[8'd21:8'd26]})
    else $error("first read beat mistimed");
  AST_BURST_HOLD: assert property (
    $fell(read_oe_n) |=> s_burst)
    else $error("first beat not held");
  AST_RELEASE_TIME: assert property (
    $rose(read_oe_n) |-> rd_age_reg inside {[8'd41:8'd46]})
    else $error("read bus released mistimed");
  AST_IDLE_RELEASED: assert property (
    rd_age_reg > 8'd46 |-> read_oe_n)
    else $error("read bus driven while idle");
endmodule
`default_nettype wire

/* File: verification/split_port_burst2_sram_interface_tb.sv */
// self-checking bench joining device and controller over the link
`timescale 1ns/1ps
`default_nettype none
module split_port_burst2_sram_interface_tb;
  localparam int DW = 36;
  localparam int AW = 8;
  localparam int MW = 4;
  logic          clk_sys;
  logic          sys_rst;
  logic          single_clock;
  logic          cmd_ready;
  logic          wr_req;
  logic          rd_req;
  logic [AW-1:0] wr_addr;
  logic [AW-1:0] rd_addr;
  logic [DW-1:0] wr_data0;
  logic [DW-1:0] wr_data1;
  logic [MW-1:0] wr_en0;
  logic [MW-1:0] wr_en1;
  logic          rd_valid;
  logic [DW-1:0] rd_data0;
  logic [DW-1:0] rd_data1;
  int            mismatches;
  int            checks_done;
  spb_link_if #(.DATA_W(DW), .ADDR_W(AW), .MASK_W(MW)) spb_link_if_i ();
  spb_device #(.DATA_W(DW), .ADDR_W(AW)) spb_device_i (
    .clk_sys, .sys_rst, .single_clock, .link(spb_link_if_i));
  spb_ctrl #(.DATA_W(DW), .ADDR_W(AW), .MASK_W(MW)) spb_ctrl_i (
    .clk_sys, .sys_rst, .cmd_ready, .wr_req, .wr_addr, .wr_data0,
    .wr_data1, .wr_en0, .wr_en1, .rd_req, .rd_addr, .rd_valid,
    .rd_data0, .rd_data1, .link(spb_link_if_i));
  spb_link_assertions #(.DATA_W(DW), .ADDR_W(AW), .MASK_W(MW)) chk_i (
    .clk_sys, .sys_rst,
    .in_strobe_pos(spb_link_if_i.in_strobe_pos),
    .in_strobe_neg(spb_link_if_i.in_strobe_neg),
    .out_strobe_pos(spb_link_if_i.out_strobe_pos),
    .write_port_sel_n(spb_link_if_i.write_port_sel_n),
    .read_port_sel_n(spb_link_if_i.read_port_sel_n),
    .word_index(spb_link_if_i.word_index),
    .write_bus(spb_link_if_i.write_bus),
    .write_mask_n(spb_link_if_i.write_mask_n),
    .read_q(spb_link_if_i.read_q),
    .read_oe_n(spb_link_if_i.read_oe_n));
  task automatic complete_run();
    $display("mismatches %0d checks %0d", mismatches, checks_done);
    if (mismatches == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic check(input string what, input logic [DW-1:0] seen,
    input logic [DW-1:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("wrong value %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic give_up();
    mismatches++;
    complete_run();
  endtask
  // request held until a ready pulse; ready only shows once per period
  task automatic issue(input logic w, r, input logic [AW-1:0] wa, ra,
    input logic [DW-1:0] d0, d1, input logic [MW-1:0] e0, e1);
    int n;
    {wr_req, rd_req, wr_addr, rd_addr} <= {w, r, wa, ra};
    {wr_data0, wr_data1, wr_en0, wr_en1} <= {d0, d1, e0, e1};
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (cmd_ready !== 1'b1 && n < 50);
    if (n >= 50)
      give_up();
    {wr_req, rd_req} <= 2'b00;
    // one edge apart so a following request is a fresh assignment
    @(posedge clk_sys);
  endtask
  task automatic expect_read(input logic [DW-1:0] x0, x1);
    int n;
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (rd_valid !== 1'b1 && n < 100);
    if (n >= 100)
      give_up();
    check("rd_data0", rd_data0, x0);
    check("rd_data1", rd_data1, x1);
  endtask
  task automatic t_basic();
    issue(1'b1, 1'b0, 8'h10, '0, 36'h123456789, 36'hfedcba987, '1, '1);
    issue(1'b0, 1'b1, '0, 8'h10, '0, '0, '0, '0);
    expect_read(36'h123456789, 36'hfedcba987);
  endtask
  // different lanes per beat shows masks are not shared across beats
  task automatic t_masks();
    issue(1'b1, 1'b0, 8'h20, '0, '1, '1, '1, '1);
    issue(1'b1, 1'b0, 8'h20, '0, '0, '0, 4'h5, 4'ha);
    issue(1'b0, 1'b1, '0, 8'h20, '0, '0, '0, '0);
    expect_read(36'hff803fe00, 36'h007fc01ff);
  endtask
  task automatic t_deselect();
    issue(1'b0, 1'b1, 8'h20, 8'h20, '0, '0, '1, '1);
    expect_read(36'hff803fe00, 36'h007fc01ff);
  endtask
  task automatic t_concurrent();
    issue(1'b1, 1'b1, 8'h30, 8'h20, 36'haaaaaaaaa, 36'h555555555, '1, '1);
    issue(1'b0, 1'b1, '0, 8'h30, '0, '0, '0, '0);
    expect_read(36'hff803fe00, 36'h007fc01ff);
    expect_read(36'haaaaaaaaa, 36'h555555555);
    // one full strobe period covers the release after the last beat
    repeat (20) @(posedge clk_sys);
    check("read_oe_n", {DW{spb_link_if_i.read_oe_n}}, {DW{1'b1}});
    check("read_bus", spb_link_if_i.read_bus, {DW{1'b0}});
  endtask
  task automatic t_single();
    single_clock <= 1'b1;
    issue(1'b0, 1'b1, '0, 8'h10, '0, '0, '0, '0);
    expect_read(36'h123456789, 36'hfedcba987);
    single_clock <= 1'b0;
  endtask
  initial
  begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  initial
  begin
    sys_rst = 1'b1;
    single_clock = 1'b0;
    {wr_req, rd_req, wr_addr, rd_addr} = '0;
    {wr_data0, wr_data1, wr_en0, wr_en1} = '0;
    mismatches = 0;
    checks_done = 0;
    repeat (10) @(posedge clk_sys);
    sys_rst <= 1'b0;
    t_basic();
    t_masks();
    t_deselect();
    t_concurrent();
    t_single();
    complete_run();
  end
endmodule
`default_nettype wire
